/* hdl/cilc_pkg.sv */
// Behaviour
// RQ1: Line zero input only, line one output only.
// RQ2: Polarity flip inverts the driven output level.
// RQ3: Source off disables and releases the output.
// RQ4: Exposure source drives the exposure window.
// RQ5: Exposure window high exactly while exposing.
// RQ6: Readout source drives the readout window.
// RQ7: Software source drives the programmed level.
// RQ8: Software level bit: zero low, one high.
// RQ9: Timer source drives the timer pulse.
// RQ10: New level accepted after stable filter time.
// RQ11: Filter time zero to 1e6 us, default 0.5us.
// RQ12: Pulses shorter than filter time are ignored.
// RQ13: Accepted edge lags raw edge by filter time.
// RQ14: Synchronise input; counter restarts on raw change.
// RQ15: Output mux and inversion are registered.
package cilc_pkg;
  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FILTER = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_LINE = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int SRC_W = 3;
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_FLIP_BIT = 3;
  localparam int CTRL_LEVEL_BIT = 4;
  localparam logic [SRC_W-1:0] SRC_OFF = 3'h0;
  localparam logic [SRC_W-1:0] SRC_EXPOSURE = 3'h1;
  localparam logic [SRC_W-1:0] SRC_READOUT = 3'h2;
  localparam logic [SRC_W-1:0] SRC_SOFTWARE = 3'h3;
  localparam logic [SRC_W-1:0] SRC_TIMER = 3'h4;
  localparam int STAT_FILT_BIT = 0;
  localparam int STAT_SYNC_BIT = 1;
  localparam int STAT_OUT_BIT = 2;
  localparam int STAT_OE_BIT = 3;
  localparam int LINE_PICK_BIT = 0;
  localparam int LINE_DIR_BIT = 1;
  // ****************************************
  // Filter timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int FILT_UNIT_NS = 100;
  localparam int FILT_CYC_PER_UNIT = FILT_UNIT_NS / CLK_PERIOD_NS;
  localparam int FILT_W = 24;
  localparam int FILT_MAX_US = 1000000;
  localparam int FILT_DEFAULT_NS = 500;
  localparam logic [FILT_W-1:0] FILT_MAX = FILT_W'(FILT_MAX_US * 1000 / FILT_UNIT_NS);
  localparam logic [FILT_W-1:0] FILT_DEFAULT = FILT_W'(FILT_DEFAULT_NS / FILT_UNIT_NS);
  localparam logic [FILT_W-1:0] CNT_MAX = 24'hFFFFFF;
endpackage

/* hdl/cilc_top.sv */
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module cilc_top import cilc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic input_line_raw,
  input wire logic exposure_active_in,
  input wire logic frame_active_in,
  input wire logic timer_pulse_out,
  output logic output_line,
  output logic output_line_oe,
  output logic input_line_filtered,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic filt;
    logic [FILT_W-1:0] cnt;
    logic [FILT_W-1:0] filt_time;
    logic [SRC_W-1:0] src;
    logic flip;
    logic sw_level;
    logic pick;
    logic out_line;
    logic out_oe;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } cilc_state_t;

  cilc_state_t s_q;
  cilc_state_t s_d;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
                                              input logic [3:0] strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_CTRL) || (a == OFS_FILTER) || (a == OFS_STATUS) || (a == OFS_LINE);
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] filt_word;
  logic [DATA_W-1:0] line_word;
  logic [DATA_W-1:0] stat_word;
  logic [DATA_W-1:0] wv;
  logic [FILT_W-1:0] thresh;
  logic src_level;

  always_comb begin
    s_d = s_q;
    ctrl_word = '0;
    ctrl_word[CTRL_SRC_LSB +: SRC_W] = s_q.src;
    ctrl_word[CTRL_FLIP_BIT] = s_q.flip;
    ctrl_word[CTRL_LEVEL_BIT] = s_q.sw_level;
    filt_word = '0;
    filt_word[FILT_W-1:0] = s_q.filt_time;
    line_word = '0;
    line_word[LINE_PICK_BIT] = s_q.pick;
    line_word[LINE_DIR_BIT] = s_q.pick; // RQ1
    stat_word = '0;
    stat_word[STAT_FILT_BIT] = s_q.filt;
    stat_word[STAT_SYNC_BIT] = s_q.sync2;
    stat_word[STAT_OUT_BIT] = s_q.out_line;
    stat_word[STAT_OE_BIT] = s_q.out_oe;
    wv = '0;
    thresh = FILT_W'(s_q.filt_time * FILT_CYC_PER_UNIT);
    src_level = 1'b0;

    // Input filter
    s_d.sync1 = input_line_raw; // RQ14
    s_d.sync2 = s_q.sync1; // RQ14
    s_d.prev = s_q.sync2;
    if (s_q.sync2 != s_q.prev) begin
      s_d.cnt = 24'h000001; // RQ14
    end else if (s_q.cnt != CNT_MAX) begin
      s_d.cnt = s_q.cnt + 24'h000001;
    end
    if ((s_q.sync2 != s_q.filt) && (s_d.cnt >= thresh)) begin
      s_d.filt = s_q.sync2; // RQ10 RQ12 RQ13
    end

    // Output source
    case (s_q.src)
      SRC_EXPOSURE: src_level = exposure_active_in; // RQ4 RQ5
      SRC_READOUT: src_level = frame_active_in; // RQ6
      SRC_SOFTWARE: src_level = s_q.sw_level; // RQ7 RQ8
      SRC_TIMER: src_level = timer_pulse_out; // RQ9
      default: src_level = 1'b0;
    endcase
    if ((s_q.src == SRC_OFF) || (s_q.src > SRC_TIMER)) begin
      s_d.out_oe = 1'b0; // RQ3
      s_d.out_line = 1'b0; // RQ3
    end else begin
      s_d.out_oe = 1'b1; // RQ15
      s_d.out_line = src_level ^ s_q.flip; // RQ2 RQ15
    end

    // Write channel
    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr;
      s_d.awready = 1'b0;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
      s_d.wready = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_q.awaddr)
        OFS_CTRL: begin
          wv = merge(ctrl_word, s_q.wdata, s_q.wstrb);
          s_d.src = wv[CTRL_SRC_LSB +: SRC_W];
          s_d.flip = wv[CTRL_FLIP_BIT];
          s_d.sw_level = wv[CTRL_LEVEL_BIT];
        end
        OFS_FILTER: begin
          wv = merge(filt_word, s_q.wdata, s_q.wstrb);
          if (wv[FILT_W-1:0] > FILT_MAX) begin
            s_d.filt_time = FILT_MAX; // RQ11
          end else begin
            s_d.filt_time = wv[FILT_W-1:0]; // RQ11
          end
        end
        OFS_LINE: begin
          wv = merge(line_word, s_q.wdata, s_q.wstrb);
          s_d.pick = wv[LINE_PICK_BIT]; // RQ1
        end
        default: wv = '0;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end

    // Read channel
    if (s_q.arready && s_axi_arvalid) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_CTRL: s_d.rdata = ctrl_word;
        OFS_FILTER: s_d.rdata = filt_word;
        OFS_STATUS: s_d.rdata = stat_word;
        OFS_LINE: s_d.rdata = line_word;
        default: s_d.rdata = '0;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // Synchronous reset
    if (!rst_n) begin
      s_d = '0;
      s_d.filt_time = FILT_DEFAULT; // RQ11
      s_d.src = SRC_OFF;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
      s_d.arready = 1'b1;
      s_d.bresp = RESP_OKAY;
      s_d.rresp = RESP_OKAY;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign output_line = s_q.out_line;
  assign output_line_oe = s_q.out_oe;
  assign input_line_filtered = s_q.filt;
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
endmodule // cilc_top

/* bench/cilc_top_monitor.sv */
`timescale 1ns/10ps
// ****
// Port checker
// ****
module cilc_monitor import cilc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic input_line_raw,
  input wire logic output_line,
  input wire logic output_line_oe,
  input wire logic input_line_filtered,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_off_low: assert property (!output_line_oe |-> !output_line)
    else $error("line high while off");
  a_oe_by_write: assert property ($changed(output_line_oe) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("enable moved without write");
  a_filt_lag: assert property ($changed(input_line_filtered) |-> input_line_filtered == $past(input_line_raw, 3))
    else $error("filtered level not from input");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("no write answer");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read answer");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer moved");
  a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer stuck");
endmodule // cilc_monitor
bind cilc_top cilc_monitor u_mon (.*);

/* bench/cilc_far_end.sv */
`timescale 1ns/10ps
// ****
// Trigger source
// ****
module cilc_far_end (
  input wire logic clk,
  output logic input_line_raw
);
  initial input_line_raw = 1'b0;
  task automatic level(input logic v, input int c);
    input_line_raw <= v;
    repeat (c) @(posedge clk);
  endtask
endmodule // cilc_far_end

/* bench/cilc_top_tb.sv */
`timescale 1ns/10ps
module cilc_top_tb import cilc_pkg::*; ;
  logic clk = 1'b0, rst_n = 1'b0, exposure_active_in = 1'b0, frame_active_in = 1'b0, timer_pulse_out = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic output_line, output_line_oe, input_line_filtered, input_line_raw;
  int n_mismatch = 0, n_compared = 0;
  always #50 clk = ~clk;
  cilc_top u_dut (.*);
  cilc_far_end u_far (.clk(clk), .input_line_raw(input_line_raw));
  // ****
  // Tasks
  // ****
  task automatic test_done();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic hang();
    n_mismatch++;
    test_done();
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pins(input logic [1:0] e);
    chk(DATA_W'({output_line_oe, output_line}), DATA_W'(e));
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] er = RESP_OKAY,
                    input logic [3:0] st = 4'hF);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    if (i == 40) hang();
    chk(DATA_W'(s_axi_bresp), DATA_W'(er));
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic [1:0] er = RESP_OKAY);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    if (i == 40) hang();
    chk(s_axi_rdata, exp);
    chk(DATA_W'(s_axi_rresp), DATA_W'(er));
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    int n;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_FILTER, 32'h5);
    pins(2'h0);
    wr(OFS_LINE, 32'h1);
    rd(OFS_LINE, 32'h3);
    wr(4'h1, 32'h7, RESP_SLVERR);
    rd(4'h1, 32'h0, RESP_SLVERR);
    for (int p = 0; p < 2; p++) begin
      for (int f = 0; f < 2; f++) begin
        for (int s = 1; s < 5; s++) begin
          exposure_active_in <= p[0];
          frame_active_in <= !p[0];
          timer_pulse_out <= p[0];
          wr(OFS_CTRL, {27'h0, !p[0], f[0], s[2:0]});
          repeat (3) @(posedge clk);
          pins({1'b1, (s == 1 || s == 4) ^ !p[0] ^ f[0]});
        end
      end
    end
    wr(OFS_CTRL, 32'h1);
    exposure_active_in <= 1'b1;
    repeat (3) @(posedge clk);
    pins(2'h3);
    rd(OFS_STATUS, 32'hC);
    exposure_active_in <= 1'b0;
    repeat (3) @(posedge clk);
    pins(2'h2);
    wr(OFS_CTRL, 32'h1D);
    repeat (3) @(posedge clk);
    pins(2'h0);
    wr(OFS_FILTER, 32'hFFFFFF);
    rd(OFS_FILTER, 32'h989680);
    wr(OFS_FILTER, 32'h1200, RESP_OKAY, 4'h2);
    rd(OFS_FILTER, 32'h981280);
    wr(OFS_FILTER, 32'h4);
    u_far.level(1'b1, 3);
    u_far.level(1'b0, 10);
    chk(DATA_W'(input_line_filtered), 32'h0);
    u_far.level(1'b1, 0);
    for (n = 0; n < 20 && input_line_filtered !== 1'b1; n++) @(posedge clk);
    if (n == 20) hang();
    chk(DATA_W'(n >= 4 && n <= 8), 32'h1);
    u_far.level(1'b0, 3);
    u_far.level(1'b1, 10);
    chk(DATA_W'(input_line_filtered), 32'h1);
    test_done();
  end
endmodule // cilc_top_tb
